// ### logic/adc_ctrl_pkg.sv
`default_nettype none
package adc_ctrl_pkg;

    // Register byte offsets on the bus
    localparam logic [11:0] OFS_MUX = 12'h000;
    localparam logic [11:0] OFS_CSA = 12'h004;
    localparam logic [11:0] OFS_CSB = 12'h008;
    localparam logic [11:0] OFS_RESL = 12'h00c;
    localparam logic [11:0] OFS_RESH = 12'h010;

    // Values after reset
    localparam logic [7:0] MUX_RESET = 8'h00;
    localparam logic [7:0] CSA_RESET = 8'h00;
    localparam logic [7:0] CSB_RESET = 8'h00;

    // input_mux_control fields
    localparam int MUX_REF_LSB = 6;
    localparam int MUX_LEFT_BIT = 5;
    // control_status_a fields
    localparam int CSA_EN_BIT = 7;
    localparam int CSA_START_BIT = 6;
    localparam int CSA_ATE_BIT = 5;
    localparam int CSA_FLAG_BIT = 4;
    localparam int CSA_IE_BIT = 3;
    // control_status_b fields
    localparam int CSB_HSM_BIT = 7;
    localparam int CSB_ISRC_BIT = 6;
    localparam int CSB_REFERENCE_PIN_BIT = 5;
    localparam int CSB_RES_BIT = 4;

    localparam logic [4:0] CHAN_LAST_VALID = 5'h12;
    localparam logic [3:0] TRIG_FREE = 4'h0;
    localparam logic [3:0] TRIG_SYNC_FIRST = 4'h7;
    localparam logic [3:0] TRIG_SYNC_LAST = 4'h9;
    localparam logic [3:0] TRIG_LAST_VALID = 4'hd;

    typedef enum logic [2:0] {
        REF_OFF = 3'b000,
        REF_EXT_PIN = 3'b001,
        REF_SUPPLY_CAP = 3'b010,
        REF_SUPPLY = 3'b011,
        REF_INT_CAP = 3'b100,
        REF_INT = 3'b101
    } ref_source_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_BUSY = 1'b1
    } conv_state_t;

    typedef struct packed {
        logic ref_pin_enable;
        logic current_source_enable;
        logic [1:0] ref_select;
    } ref_ctrl_t;

    typedef struct packed {
        logic init;
        logic chan_valid;
        logic [4:0] channel;
        ref_source_t ref_source;
    } conv_cmd_t;

    function automatic ref_source_t ref_decode(input ref_ctrl_t r);
        case (r)
            4'b1000: ref_decode = REF_EXT_PIN;
            4'b1001: ref_decode = REF_SUPPLY_CAP;
            4'b0001: ref_decode = REF_SUPPLY;
            4'b1011: ref_decode = REF_INT_CAP;
            4'b0011: ref_decode = REF_INT;
            4'b0111: ref_decode = REF_INT;
            default: ref_decode = REF_OFF;
        endcase
    endfunction : ref_decode

endpackage : adc_ctrl_pkg
`default_nettype wire

// ### logic/adc_control_registers.sv
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - Reference chosen from pin enable, current source enable and two select bits.
// - Reference select written mid-conversion applies only after that conversion completes.
// - Left adjust bit changes the visible result layout immediately, even mid-conversion.
// - Channel codes 0-18 map to inputs and internal sources; above 18 reserved.
// - Channel written mid-conversion applies only after the running conversion completes.
// - Enable bit turns converter on; clearing mid-conversion acts at conversion end.
// - Writing one starts a conversion; hardware clears it at completion; zero ignored.
// - First conversion after enabling also runs the converter initialization.
// - Auto trigger enable selects triggered mode; clearing returns to single mode.
// - Done flag set at completion; cleared by vector acknowledge or writing one.
// - End-of-conversion interrupt request raised only while its enable is set.
// - Converter clock divides system clock by 2,2,4,8,16,32,64,128 per code.
// - High speed mode bit enables high speed operation; software picks it by rate.
// - Current source enable drives the 100uA source onto the reference pin.
// - Reference pin enable connects the internal reference circuit to the pin.
// - Bit 4 of control_status_b is unused and always reads zero.
// - Trigger select decodes free run, timers, interrupt, sync events, comparators.
// - Auto-trigger starts on rising edge of the selected source flag.
// - Sync event starts a conversion at each occurrence if previous one completed.
// - Trigger select acts only while auto trigger is enabled.
// - Internal reference, only when it is the selected reference, powers on once the converter or another analog feature needing it is active.
// - Reading result low blocks result updates until result high is read.
// - Left adjusted result puts upper eight bits into result high.
module adc_control_registers #(
    parameter int RESULT_BITS = 10
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Conversion engine
    output logic conv_start,
    output adc_ctrl_pkg::conv_cmd_t conv_cmd,
    output logic adc_clk_en,
    output logic converter_on,
    output logic high_speed,
    input wire logic conv_done,
    input wire logic [RESULT_BITS-1:0] conv_result,
    // Reference pin and internal reference
    output logic current_source_on,
    output logic ref_pin_connect,
    output logic internal_ref_on,
    input wire logic analog_ref_demand,
    // Trigger sources, index equals trigger code
    input wire logic [13:1] trig_in,
    // Interrupt request and vector acknowledge
    output logic irq,
    input wire logic irq_ack
);

    if (RESULT_BITS != 10) begin : g_bad_width
        $error("RESULT_BITS must be 10");
    end

    logic [7:0] mux_q, mux_d, csa_q, csa_d, csb_q, csb_d;
    logic [9:0] result_q, result_d;
    logic lock_q, lock_d;
    adc_ctrl_pkg::conv_state_t state_q, state_d;
    adc_ctrl_pkg::conv_cmd_t cmd_q, cmd_d;
    logic init_pending_q, init_pending_d;
    logic start_q, start_d, on_q, on_d, irq_q, irq_d, iref_q, iref_d;
    logic [13:1] trig_prev_q;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d;
    logic [6:0] presc_q, presc_d, presc_mask;
    logic clk_en_q, clk_en_d;
    logic wr_en, rd_en, wr_mux, wr_csa, wr_csb, rd_resl, rd_resh;
    logic busy, done_ev, en_bit, auto_hit, pending_single, start_fire;
    logic [7:0] res_high, res_low;
    adc_ctrl_pkg::ref_ctrl_t ref_ctrl;

    // Bus side
    assign wr_en = psel && penable && pready_q && pwrite;
    assign rd_en = psel && penable && pready_q && !pwrite;
    assign wr_mux = wr_en && (paddr == adc_ctrl_pkg::OFS_MUX);
    assign wr_csa = wr_en && (paddr == adc_ctrl_pkg::OFS_CSA);
    assign wr_csb = wr_en && (paddr == adc_ctrl_pkg::OFS_CSB);
    assign rd_resl = rd_en && (paddr == adc_ctrl_pkg::OFS_RESL);
    assign rd_resh = rd_en && (paddr == adc_ctrl_pkg::OFS_RESH);

    // Layout follows the live adjust bit, not the one at conversion time
    always_comb
    begin
        if (mux_q[adc_ctrl_pkg::MUX_LEFT_BIT])
        begin
            res_high = result_q[9:2];
            res_low = {result_q[1:0], 6'h00};
        end
        else
        begin
            res_high = {6'h00, result_q[9:8]};
            res_low = result_q[7:0];
        end
    end

    // Data is sampled in the setup cycle so pready can come from a flop
    always_comb
    begin
        prdata_d = 32'h0000_0000;
        pslverr_d = 1'b0;
        pready_d = psel && !penable && !pready_q;
        if (paddr == adc_ctrl_pkg::OFS_MUX)
        begin
            prdata_d[7:0] = mux_q;
        end
        else if (paddr == adc_ctrl_pkg::OFS_CSA)
        begin
            prdata_d[7:0] = csa_q;
        end
        else if (paddr == adc_ctrl_pkg::OFS_CSB)
        begin
            prdata_d[7:0] = csb_q & ~(8'h01 << adc_ctrl_pkg::CSB_RES_BIT);
        end
        else if (paddr == adc_ctrl_pkg::OFS_RESL)
        begin
            prdata_d[7:0] = res_low;
        end
        else if (paddr == adc_ctrl_pkg::OFS_RESH)
        begin
            prdata_d[7:0] = res_high;
        end
        else
        begin
            pslverr_d = pready_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            if (pready_d)
            begin
                prdata_q <= prdata_d;
            end
        end
    end

    // Conversion control
    assign en_bit = csa_q[adc_ctrl_pkg::CSA_EN_BIT];
    assign busy = (state_q == adc_ctrl_pkg::ST_BUSY);
    assign done_ev = conv_done && busy;
    assign ref_ctrl = {csb_q[adc_ctrl_pkg::CSB_REFERENCE_PIN_BIT], csb_q[adc_ctrl_pkg::CSB_ISRC_BIT],
                       mux_q[adc_ctrl_pkg::MUX_REF_LSB +: 2]};

    always_comb
    begin
        auto_hit = 1'b0;
        if (csb_q[3:0] == adc_ctrl_pkg::TRIG_FREE)
        begin
            auto_hit = done_ev;
        end
        else if (csb_q[3:0] >= adc_ctrl_pkg::TRIG_SYNC_FIRST &&
                 csb_q[3:0] <= adc_ctrl_pkg::TRIG_SYNC_LAST)
        begin
            // Sync events carry no flag, each pulse counts
            auto_hit = trig_in[csb_q[3:0]];
        end
        else if (csb_q[3:0] <= adc_ctrl_pkg::TRIG_LAST_VALID)
        begin
            auto_hit = trig_in[csb_q[3:0]] && !trig_prev_q[csb_q[3:0]];
        end
        // Reserved codes leave auto_hit low
    end

    assign pending_single = csa_q[adc_ctrl_pkg::CSA_START_BIT] && !busy;
    // A trigger arriving while busy is dropped; completion frees the slot
    assign start_fire = en_bit && (!busy || done_ev) && (pending_single ||
                        (csa_q[adc_ctrl_pkg::CSA_ATE_BIT] && auto_hit));

    always_comb
    begin
        mux_d = mux_q;
        csa_d = csa_q;
        csb_d = csb_q;
        state_d = state_q;
        cmd_d = cmd_q;
        init_pending_d = init_pending_q;
        result_d = result_q;
        lock_d = lock_q;
        if (wr_mux)
        begin
            mux_d = pwdata[7:0];
        end
        if (wr_csb)
        begin
            csb_d = pwdata[7:0] & ~(8'h01 << adc_ctrl_pkg::CSB_RES_BIT);
        end
        if (wr_csa)
        begin
            csa_d[adc_ctrl_pkg::CSA_EN_BIT] = pwdata[adc_ctrl_pkg::CSA_EN_BIT];
            csa_d[adc_ctrl_pkg::CSA_ATE_BIT] = pwdata[adc_ctrl_pkg::CSA_ATE_BIT];
            csa_d[adc_ctrl_pkg::CSA_IE_BIT] = pwdata[adc_ctrl_pkg::CSA_IE_BIT];
            csa_d[2:0] = pwdata[2:0];
            if (pwdata[adc_ctrl_pkg::CSA_START_BIT] && pwdata[adc_ctrl_pkg::CSA_EN_BIT])
            begin
                csa_d[adc_ctrl_pkg::CSA_START_BIT] = 1'b1;
            end
            if (pwdata[adc_ctrl_pkg::CSA_FLAG_BIT])
            begin
                csa_d[adc_ctrl_pkg::CSA_FLAG_BIT] = 1'b0;
            end
        end
        if (irq_ack)
        begin
            csa_d[adc_ctrl_pkg::CSA_FLAG_BIT] = 1'b0;
        end
        if (!on_q)
        begin
            init_pending_d = 1'b1;
        end
        if (done_ev)
        begin
            state_d = adc_ctrl_pkg::ST_IDLE;
            csa_d[adc_ctrl_pkg::CSA_START_BIT] = 1'b0;
            csa_d[adc_ctrl_pkg::CSA_FLAG_BIT] = 1'b1;
            if (!lock_q)
            begin
                result_d = conv_result;
            end
        end
        if (start_fire)
        begin
            state_d = adc_ctrl_pkg::ST_BUSY;
            csa_d[adc_ctrl_pkg::CSA_START_BIT] = 1'b1;
            init_pending_d = 1'b0;
        end
        // Selections track the registers only between conversions
        if (start_fire || !busy)
        begin
            cmd_d.init = init_pending_q;
            cmd_d.channel = mux_q[4:0];
            cmd_d.chan_valid = (mux_q[4:0] <= adc_ctrl_pkg::CHAN_LAST_VALID);
            cmd_d.ref_source = adc_ctrl_pkg::ref_decode(ref_ctrl);
        end
        if (rd_resl)
        begin
            lock_d = 1'b1;
        end
        else if (rd_resh)
        begin
            lock_d = 1'b0;
        end
    end

    // Outputs derived from control state
    always_comb
    begin
        start_d = start_fire;
        on_d = en_bit || busy;
        irq_d = csa_q[adc_ctrl_pkg::CSA_FLAG_BIT] && csa_q[adc_ctrl_pkg::CSA_IE_BIT];
        iref_d = (cmd_q.ref_source == adc_ctrl_pkg::REF_INT ||
                  cmd_q.ref_source == adc_ctrl_pkg::REF_INT_CAP) &&
                 (on_q || analog_ref_demand);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mux_q <= adc_ctrl_pkg::MUX_RESET;
            csa_q <= adc_ctrl_pkg::CSA_RESET;
            csb_q <= adc_ctrl_pkg::CSB_RESET;
            state_q <= adc_ctrl_pkg::ST_IDLE;
            cmd_q <= '0;
            init_pending_q <= 1'b1;
            result_q <= 10'h000;
            lock_q <= 1'b0;
            trig_prev_q <= 13'h0000;
            start_q <= 1'b0;
            on_q <= 1'b0;
            irq_q <= 1'b0;
            iref_q <= 1'b0;
        end
        else
        begin
            mux_q <= mux_d;
            csa_q <= csa_d;
            csb_q <= csb_d;
            state_q <= state_d;
            cmd_q <= cmd_d;
            init_pending_q <= init_pending_d;
            result_q <= result_d;
            lock_q <= lock_d;
            trig_prev_q <= trig_in;
            start_q <= start_d;
            on_q <= on_d;
            irq_q <= irq_d;
            iref_q <= iref_d;
        end
    end

    // Prescaler: free counter, tick when the low bits under the mask are all ones
    always_comb
    begin
        case (csa_q[2:0])
            3'h2: presc_mask = 7'h03;
            3'h3: presc_mask = 7'h07;
            3'h4: presc_mask = 7'h0f;
            3'h5: presc_mask = 7'h1f;
            3'h6: presc_mask = 7'h3f;
            3'h7: presc_mask = 7'h7f;
            default: presc_mask = 7'h01;
        endcase
        presc_d = on_q ? presc_q + 7'h01 : 7'h00;
        clk_en_d = on_q && ((presc_q & presc_mask) == presc_mask);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            presc_q <= 7'h00;
            clk_en_q <= 1'b0;
        end
        else
        begin
            presc_q <= presc_d;
            clk_en_q <= clk_en_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign conv_start = start_q;
    assign conv_cmd = cmd_q;
    assign adc_clk_en = clk_en_q;
    assign converter_on = on_q;
    assign high_speed = csb_q[adc_ctrl_pkg::CSB_HSM_BIT];
    assign current_source_on = csb_q[adc_ctrl_pkg::CSB_ISRC_BIT];
    assign ref_pin_connect = csb_q[adc_ctrl_pkg::CSB_REFERENCE_PIN_BIT];
    assign internal_ref_on = iref_q;
    assign irq = irq_q;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_done_sets_flag: assert property (done_ev |=> csa_q[4] ##1 (csa_q[4] || $past(irq_ack) || $past(wr_csa))) else $error("done did not set flag");
    a_flag_write_one: assert property ((wr_csa && pwdata[4] && !done_ev) |=> !csa_q[4] ##1 !irq) else $error("flag not cleared by write one");
    a_irq_gated: assert property (!csa_q[3] |=> !irq) else $error("irq raised while disabled");
    a_start_clears: assert property ((done_ev && !start_fire) |=> !csa_q[6] && !busy) else $error("start bit not cleared at completion");
    a_start_zero_write: assert property ((wr_csa && !pwdata[6] && csa_q[6] && !done_ev) |=> csa_q[6]) else $error("writing zero cleared start");
    a_channel_held: assert property ((busy && !done_ev) |=> $stable(conv_cmd.channel)) else $error("channel changed mid-conversion");
    a_ref_held: assert property ((busy && !done_ev) |=> $stable(conv_cmd.ref_source)) else $error("reference changed mid-conversion");
    a_enable_holds_on: assert property ((busy && !en_bit) |=> converter_on) else $error("converter off while converting");
    a_single_needs_bit: assert property ((conv_start && !$past(csa_q[5])) |-> $past(csa_q[6])) else $error("start without start bit in single mode");
    a_reserved_trigger: assert property ((csa_q[5] && !csa_q[6] && csb_q[3:0] > 4'hd) |=> !conv_start) else $error("reserved trigger started conversion");
    a_result_locked: assert property ((lock_q && !rd_resh) |=> $stable(result_q)) else $error("result changed while locked");
    a_init_first: assert property ((conv_start && $past(init_pending_q)) |-> conv_cmd.init) else $error("first conversion lacked init");

    c_single_conv: cover property (conv_start ##[1:300] done_ev);
    c_auto_trigger: cover property (csa_q[5] && auto_hit && start_fire);
    c_locked_update: cover property (lock_q && done_ev);
    c_free_running: cover property (done_ev && start_fire);

endmodule : adc_control_registers
`default_nettype wire

// ### dv/adc_control_registers_test.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module adc_control_registers_test;
    logic pclk, presetn, psel, penable, pwrite, conv_done, analog_ref_demand, irq_ack;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, conv_start, adc_clk_en, converter_on, high_speed, irq;
    logic current_source_on, ref_pin_connect, internal_ref_on;
    adc_ctrl_pkg::conv_cmd_t conv_cmd;
    logic [9:0] conv_result;
    logic [13:1] trig_in;
    logic [7:0] rv;
    logic [23:0] rhi;
    logic ev;
    int error_cnt = 0;
    int checks = 0;
    int starts = 0;
    int s0;

    adc_control_registers DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .conv_start(conv_start), .conv_cmd(conv_cmd),
        .adc_clk_en(adc_clk_en), .converter_on(converter_on), .high_speed(high_speed),
        .conv_done(conv_done), .conv_result(conv_result),
        .current_source_on(current_source_on), .ref_pin_connect(ref_pin_connect),
        .internal_ref_on(internal_ref_on), .analog_ref_demand(analog_ref_demand),
        .trig_in(trig_in), .irq(irq), .irq_ack(irq_ack));

    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // Every start pulse is counted so that missing or extra starts both show
    always @(posedge pclk)
        if (conv_start === 1'b1)
            starts <= starts + 1;

    task automatic end_of_test;
        $display("Checks %0d, errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test

    task automatic nc(input int n);
        repeat (n) @(negedge pclk);
    endtask : nc

    // Answer is taken at the very edge where pready is seen high; a hang is left to the watchdog
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rv = prdata[7:0];
        rhi = prdata[31:8];
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rchk(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        `CHK({rhi, ev, rv}, {24'h000000, 1'b0, e})
    endtask : rchk

    task automatic done_pulse(input logic [9:0] r);
        @(posedge pclk);
        conv_done <= 1'b1;
        conv_result <= r;
        @(posedge pclk);
        conv_done <= 1'b0;
    endtask : done_pulse

    task automatic trig(input logic [13:1] v);
        @(posedge pclk);
        trig_in <= v;
    endtask : trig

    task automatic t_regs;
        rchk(adc_ctrl_pkg::OFS_MUX, 8'h00);
        rchk(adc_ctrl_pkg::OFS_CSA, 8'h00);
        rchk(adc_ctrl_pkg::OFS_CSB, 8'h00);
        apb(1'b0, 12'h014, 8'h00);
        `CHK({ev, rv}, 9'h100)
        apb(1'b1, adc_ctrl_pkg::OFS_CSB, 8'hff);
        rchk(adc_ctrl_pkg::OFS_CSB, 8'hef);
        `CHK({high_speed, current_source_on, ref_pin_connect}, 3'b111)
        apb(1'b1, adc_ctrl_pkg::OFS_CSB, 8'h10);
        rchk(adc_ctrl_pkg::OFS_CSB, 8'h00);
        `CHK({high_speed, current_source_on, ref_pin_connect}, 3'b000)
        $display("t_regs done");
    endtask : t_regs

    task automatic t_decode;
        logic [3:0] sel [7] = '{4'b1000, 4'b1001, 4'b0001, 4'b1010, 4'b1011, 4'b0011, 4'b0111};
        logic [2:0] exp [7] = '{3'd1, 3'd2, 3'd3, 3'd0, 3'd4, 3'd5, 3'd5};
        logic [4:0] ch [5] = '{5'd0, 5'd10, 5'd11, 5'd18, 5'd19};
        @(posedge pclk);
        analog_ref_demand <= 1'b1;
        for (int i = 0; i < 7; i++)
        begin
            apb(1'b1, adc_ctrl_pkg::OFS_CSB, {1'b0, sel[i][2], sel[i][3], 5'h00});
            apb(1'b1, adc_ctrl_pkg::OFS_MUX, {sel[i][1:0], 6'h00});
            // The power request follows the in-use reference one cycle later
            nc(3);
            `CHK(conv_cmd.ref_source, exp[i])
            `CHK(internal_ref_on, exp[i] >= 3'd4)
        end
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b1, adc_ctrl_pkg::OFS_MUX, {3'b000, ch[i]});
            nc(2);
            `CHK({conv_cmd.chan_valid, conv_cmd.channel}, {ch[i] <= 5'd18, ch[i]})
        end
        @(posedge pclk);
        analog_ref_demand <= 1'b0;
        apb(1'b1, adc_ctrl_pkg::OFS_CSB, 8'h00);
        $display("t_decode done");
    endtask : t_decode

    task automatic t_single;
        apb(1'b1, adc_ctrl_pkg::OFS_MUX, 8'h05);
        s0 = starts;
        apb(1'b1, adc_ctrl_pkg::OFS_CSA, 8'hc8);
        nc(3);
        `CHK(starts, s0 + 1)
        `CHK({conv_cmd.init, conv_cmd.channel}, 6'h25)
        apb(1'b1, adc_ctrl_pkg::OFS_MUX, 8'hc7);
        nc(2);
        `CHK({conv_cmd.channel, conv_cmd.ref_source}, {5'd5, 3'd0})
        // Clearing enable and writing start as zero while busy
        apb(1'b1, adc_ctrl_pkg::OFS_CSA, 8'h08);
        rchk(adc_ctrl_pkg::OFS_CSA, 8'h48);
        `CHK(converter_on, 1'b1)
        done_pulse(10'h2a5);
        nc(3);
        `CHK({converter_on, irq}, 2'b01)
        rchk(adc_ctrl_pkg::OFS_CSA, 8'h18);
        `CHK({conv_cmd.channel, conv_cmd.ref_source}, {5'd7, 3'd5})
        rchk(adc_ctrl_pkg::OFS_RESL, 8'ha5);
        rchk(adc_ctrl_pkg::OFS_RESH, 8'h02);
        apb(1'b1, adc_ctrl_pkg::OFS_MUX, 8'he7);
        rchk(adc_ctrl_pkg::OFS_RESL, 8'h40);
        rchk(adc_ctrl_pkg::OFS_RESH, 8'ha9);
        apb(1'b1, adc_ctrl_pkg::OFS_CSA, 8'h00);
        nc(2);
        `CHK(irq, 1'b0)
        rchk(adc_ctrl_pkg::OFS_CSA, 8'h10);
        apb(1'b1, adc_ctrl_pkg::OFS_CSA, 8'h10);
        rchk(adc_ctrl_pkg::OFS_CSA, 8'h00);
        $display("t_single done");
    endtask : t_single

    task automatic t_lock;
        rchk(adc_ctrl_pkg::OFS_RESL, 8'h40);
        apb(1'b1, adc_ctrl_pkg::OFS_CSA, 8'hc0);
        nc(2);
        `CHK(conv_cmd.init, 1'b1)
        done_pulse(10'h3ff);
        nc(2);
        rchk(adc_ctrl_pkg::OFS_RESH, 8'ha9);
        // A result that completes while locked is dropped, not deferred
        rchk(adc_ctrl_pkg::OFS_RESL, 8'h40);
        rchk(adc_ctrl_pkg::OFS_RESH, 8'ha9);
        apb(1'b1, adc_ctrl_pkg::OFS_CSA, 8'hd0);
        nc(2);
        `CHK(conv_cmd.init, 1'b0)
        done_pulse(10'h3ff);
        @(posedge pclk);
        irq_ack <= 1'b1;
        @(posedge pclk);
        irq_ack <= 1'b0;
        rchk(adc_ctrl_pkg::OFS_CSA, 8'h80);
        rchk(adc_ctrl_pkg::OFS_RESL, 8'hc0);
        rchk(adc_ctrl_pkg::OFS_RESH, 8'hff);
        $display("t_lock done");
    endtask : t_lock

    task automatic t_presc;
        int divs [8] = '{2, 2, 4, 8, 16, 32, 64, 128};
        int n;
        for (int i = 0; i < 8; i++)
        begin
            apb(1'b1, adc_ctrl_pkg::OFS_CSA, 8'h80 | 8'(i));
            // Skip the phase settling after a divider change
            nc(130);
            n = 0;
            repeat (256)
            begin
                @(negedge pclk);
                if (adc_clk_en === 1'b1)
                    n++;
            end
            `CHK(n, 256 / divs[i])
        end
        $display("t_presc done");
    endtask : t_presc

    task automatic t_auto;
        apb(1'b1, adc_ctrl_pkg::OFS_CSA, 8'hb0);
        for (int c = 1; c < 14; c++)
        begin
            if (c < 7 || c > 9)
            begin
                apb(1'b1, adc_ctrl_pkg::OFS_CSB, 8'(c));
                s0 = starts;
                trig(13'h0001 << (c - 1));
                nc(3);
                `CHK(starts, s0 + 1)
                done_pulse(10'h000);
                nc(3);
                `CHK(starts, s0 + 1)
                trig(13'h0000);
            end
        end
        apb(1'b1, adc_ctrl_pkg::OFS_CSB, 8'h0e);
        s0 = starts;
        trig(13'h1fff);
        nc(3);
        `CHK(starts, s0)
        trig(13'h0000);
        apb(1'b1, adc_ctrl_pkg::OFS_CSB, 8'h07);
        trig(13'h0040);
        trig(13'h0000);
        nc(2);
        `CHK(starts, s0 + 1)
        trig(13'h0040);
        trig(13'h0000);
        nc(2);
        `CHK(starts, s0 + 1)
        done_pulse(10'h000);
        trig(13'h0040);
        trig(13'h0000);
        nc(2);
        `CHK(starts, s0 + 2)
        done_pulse(10'h000);
        apb(1'b1, adc_ctrl_pkg::OFS_CSA, 8'h90);
        apb(1'b1, adc_ctrl_pkg::OFS_CSB, 8'h01);
        trig(13'h0001);
        nc(3);
        `CHK(starts, s0 + 2)
        trig(13'h0000);
        apb(1'b1, adc_ctrl_pkg::OFS_CSB, 8'h00);
        apb(1'b1, adc_ctrl_pkg::OFS_CSA, 8'hf0);
        nc(3);
        `CHK(starts, s0 + 3)
        done_pulse(10'h000);
        nc(3);
        `CHK(starts, s0 + 4)
        $display("t_auto done");
    endtask : t_auto

    initial
    begin
        presetn = 1'b0;
        {psel, penable, pwrite, conv_done, analog_ref_demand, irq_ack} = '0;
        paddr = '0;
        pwdata = '0;
        conv_result = '0;
        trig_in = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        nc(1);
        `CHK({irq, converter_on, conv_start}, 3'b000)
        t_regs();
        t_decode();
        t_single();
        t_lock();
        t_presc();
        t_auto();
        end_of_test();
    end

    // A hung handshake ends the run well after the tests would have finished
    initial
    begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        end_of_test();
    end
endmodule : adc_control_registers_test
`default_nettype wire
